//--- rtl/dgrc_top.v
// Purpose: Geometry and refresh control of a DDR2 memory controller.
// Assumes: Wishbone classic slave, single clock, synchronous reset.
// Notes: Command scheduling and the physical side live elsewhere.
// Behaviour
// - Bank count field: 0,1,2,3 give one, two, four, eight banks; rest reserved.
// - Page size field: 0..3 give 256..2048 words, 8..11 column bits.
// - Setting the self-refresh request puts the memory into self-refresh.
// - Clearing the self-refresh request brings the memory out again.
// - Memory clock may stop in self-refresh only when halting is permitted.
// - Refresh interval field is 16 bits, counted in controller cycles.
// - Changing drive, CAS latency, bank count or page size starts initialization.
`include "dgrc_defs.vh"

module dgrc_top (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    output reg err_o,
    // Geometry to the address mapper
    output reg [3:0] bank_count_o,
    output reg [3:0] column_bits_o,
    output reg geometry_valid_o,
    // Controller side
    output reg init_start_o,
    output wire refresh_req_o,
    output reg self_refresh_o,
    output reg mem_clk_enable_o
);

    localparam ST_NORMAL = 2'd0;
    localparam ST_SETTLE = 2'd1;
    localparam ST_SELFREF = 2'd2;

    reg [31:0] bank_cfg_ff;
    reg [31:0] refresh_ff;
    reg [1:0] state_ff;
    reg [3:0] settle_ff;
    reg [1:0] nxt_state;
    reg [3:0] nxt_settle;
    reg [31:0] nxt_bank;
    reg [31:0] nxt_refresh;
    reg [31:0] rd_data;
    wire access;
    wire hit;
    wire wr_bank;
    wire wr_refresh;

    // Byte-lane merge, used for both registers.
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] lanes;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1) begin
                merge[i*8 +: 8] = lanes[i] ? new_v[i*8 +: 8] : old_v[i*8 +: 8];
            end
        end
    endfunction

    // Bank count from its code; reserved codes give zero so the mapper can tell.
    function [3:0] bank_decode;
        input [2:0] code;
        begin
            case (code)
                3'h0: bank_decode = 4'h1;
                3'h1: bank_decode = 4'h2;
                3'h2: bank_decode = 4'h4;
                3'h3: bank_decode = 4'h8;
                default: bank_decode = 4'h0;
            endcase
        end
    endfunction

    // Column address bits from the page code; reserved codes give zero.
    function [3:0] page_decode;
        input [2:0] code;
        begin
            case (code)
                3'h0: page_decode = 4'h8;
                3'h1: page_decode = 4'h9;
                3'h2: page_decode = 4'hA;
                3'h3: page_decode = 4'hB;
                default: page_decode = 4'h0;
            endcase
        end
    endfunction

    // True when a memory-facing field differs; reserved bits never count.
    function fields_differ;
        input [31:0] old_v;
        input [31:0] new_v;
        begin
            fields_differ = (new_v[`DGRC_DRIVE_BIT] != old_v[`DGRC_DRIVE_BIT]) ||
                (new_v[`DGRC_CAS_HI:`DGRC_CAS_LO] != old_v[`DGRC_CAS_HI:`DGRC_CAS_LO]) ||
                (new_v[`DGRC_BANK_HI:`DGRC_BANK_LO] != old_v[`DGRC_BANK_HI:`DGRC_BANK_LO]) ||
                (new_v[`DGRC_PAGE_HI:`DGRC_PAGE_LO] != old_v[`DGRC_PAGE_HI:`DGRC_PAGE_LO]);
        end
    endfunction

    assign access = cyc_i && stb_i && !ack_o && !err_o;
    assign hit = (adr_i == `DGRC_OFS_BANK_CFG) || (adr_i == `DGRC_OFS_REFRESH) || (adr_i == `DGRC_OFS_STATUS);
    assign wr_bank = access && we_i && (adr_i == `DGRC_OFS_BANK_CFG);
    assign wr_refresh = access && we_i && (adr_i == `DGRC_OFS_REFRESH);

    always @* begin
        // Reserved bits are not stored; software keeps bit 3 at zero anyway.
        nxt_bank = merge(bank_cfg_ff, dat_i, sel_i) & ~`DGRC_BANK_RESERVED_MASK;
        nxt_refresh = merge(refresh_ff, dat_i, sel_i) & ~`DGRC_REFRESH_RESERVED_MASK;
        case (adr_i)
            `DGRC_OFS_BANK_CFG: rd_data = bank_cfg_ff;
            `DGRC_OFS_REFRESH: rd_data = refresh_ff;
            // Status shows self-refresh from the request on, settle time included, so software cannot poll it for a settled self-refresh.
            `DGRC_OFS_STATUS: rd_data = {29'h0000_0000, mem_clk_enable_o, self_refresh_o, geometry_valid_o};
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            bank_cfg_ff <= `DGRC_BANK_RESET;
            refresh_ff <= `DGRC_REFRESH_RESET;
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
            init_start_o <= 1'b0;
        end else begin
            ack_o <= access && hit;
            err_o <= access && !hit;
            init_start_o <= 1'b0;
            if (access && hit) begin
                dat_o <= rd_data;
            end
            if (wr_bank) begin
                bank_cfg_ff <= nxt_bank;
                // Only a real change of the memory-facing fields restarts init.
                if (fields_differ(bank_cfg_ff, nxt_bank)) begin
                    init_start_o <= 1'b1;
                end
            end
            if (wr_refresh) begin
                refresh_ff <= nxt_refresh;
            end
        end
    end

    // Geometry decode; reserved codes report zero and clear the valid flag.
    always @(posedge clk_i) begin
        if (rst_i) begin
            bank_count_o <= 4'h0;
            column_bits_o <= 4'h0;
            geometry_valid_o <= 1'b0;
        end else begin
            bank_count_o <= bank_decode(bank_cfg_ff[`DGRC_BANK_HI:`DGRC_BANK_LO]);
            column_bits_o <= page_decode(bank_cfg_ff[`DGRC_PAGE_HI:`DGRC_PAGE_LO]);
            geometry_valid_o <= !bank_cfg_ff[`DGRC_BANK_HI] && !bank_cfg_ff[`DGRC_PAGE_HI];
        end
    end

    // Self-refresh sequencing: the clock stops only after a settle time.
    always @* begin
        nxt_state = state_ff;
        nxt_settle = settle_ff;
        case (state_ff)
            ST_NORMAL: begin
                if (refresh_ff[`DGRC_SELF_REFRESH_BIT]) begin
                    nxt_state = ST_SETTLE;
                    nxt_settle = `DGRC_SR_SETTLE_CYCLES;
                end
            end
            ST_SETTLE: begin
                if (!refresh_ff[`DGRC_SELF_REFRESH_BIT]) begin
                    nxt_state = ST_NORMAL;
                end else if (settle_ff == 4'h0) begin
                    nxt_state = ST_SELFREF;
                end else begin
                    nxt_settle = settle_ff - 4'h1;
                end
            end
            ST_SELFREF: begin
                if (!refresh_ff[`DGRC_SELF_REFRESH_BIT]) begin
                    nxt_state = ST_NORMAL;
                end
            end
            default: nxt_state = ST_NORMAL;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= ST_NORMAL;
            settle_ff <= 4'h0;
            self_refresh_o <= 1'b0;
            mem_clk_enable_o <= 1'b1;
        end else begin
            state_ff <= nxt_state;
            settle_ff <= nxt_settle;
            self_refresh_o <= (nxt_state != ST_NORMAL);
            // The halt permit is honoured only once self-refresh has settled.
            mem_clk_enable_o <= !(nxt_state == ST_SELFREF && refresh_ff[`DGRC_CLK_HALT_BIT]);
        end
    end

    // A new interval takes effect only at the next reload, so moving from a long
    // interval to a short one lets the long count run out first.
    dgrc_refresh_timer u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .run_i(!self_refresh_o),
        .interval_i(refresh_ff[`DGRC_INTERVAL_HI:0]),
        .refresh_req_o(refresh_req_o)
    );

endmodule

//--- rtl/dgrc_defs.vh
// Purpose: Constants for the DDR2 geometry and refresh control block.
// Assumes: Wishbone classic slave with 32-bit data, byte addresses.
// Notes: Offsets are local to this block.
`ifndef DGRC_DEFS_VH
`define DGRC_DEFS_VH

`define DGRC_OFS_BANK_CFG 8'h00
`define DGRC_OFS_REFRESH 8'h04
`define DGRC_OFS_STATUS 8'h08

`define DGRC_BANK_RESERVED_MASK 32'hFFFB_B188
`define DGRC_BANK_RESET 32'h0000_0000
`define DGRC_REFRESH_RESERVED_MASK 32'h3FFF_0000
`define DGRC_REFRESH_RESET 32'h0000_0000

`define DGRC_DRIVE_BIT 18
`define DGRC_CAS_HI 11
`define DGRC_CAS_LO 9
`define DGRC_BANK_HI 6
`define DGRC_BANK_LO 4
`define DGRC_PAGE_HI 2
`define DGRC_PAGE_LO 0
`define DGRC_SELF_REFRESH_BIT 31
`define DGRC_CLK_HALT_BIT 30
`define DGRC_INTERVAL_HI 15

// Cycles the memory needs to settle into self-refresh before its clock may stop.
`define DGRC_SR_SETTLE_CYCLES 4'h4

`endif

//--- rtl/dgrc_refresh_timer.v
// Purpose: Down-counter that posts one auto-refresh request per interval.
// Assumes: Interval is counted in controller clock cycles.
// Notes: Reloaded with the interval every cycle while the memory is in self-refresh.
`include "dgrc_defs.vh"

module dgrc_refresh_timer (
    // Clock and reset
    input wire clk_i,
    input wire rst_i,
    // Control
    input wire run_i,
    input wire [15:0] interval_i,
    // Request
    output reg refresh_req_o
);

    reg [15:0] count_ff;

    always @(posedge clk_i) begin
        if (rst_i) begin
            count_ff <= 16'h0000;
            refresh_req_o <= 1'b0;
        end else begin
            refresh_req_o <= 1'b0;
            if (!run_i) begin
                count_ff <= interval_i;
            end else if (count_ff == 16'h0000) begin
                // An interval of zero therefore requests every cycle.
                refresh_req_o <= 1'b1;
                count_ff <= interval_i;
            end else begin
                count_ff <= count_ff - 16'h0001;
            end
        end
    end

endmodule

//--- tb/dgrc_chk.sv
// Purpose: Assertions on the geometry and refresh control block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to the top module.
module dgrc_chk (
    input wire logic clk_i, rst_i, we_i, ack_o, geometry_valid_o,
    input wire logic init_start_o, refresh_req_o, self_refresh_o, mem_clk_enable_o,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i, bank_count_o, column_bits_o,
    input wire logic [31:0] dat_i
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire sr_wr = ack_o && we_i && adr_i == 8'h04 && sel_i[3];
    a_geom_legal: assert property (
        geometry_valid_o |-> bank_count_o inside {4'h1, 4'h2, 4'h4, 4'h8} && column_bits_o inside {[4'h8:4'hb]})
        else $error("bad geometry");
    a_geom_reserved: assert property (
        !geometry_valid_o |-> bank_count_o == 4'h0 || column_bits_o == 4'h0) else $error("bad reserved");
    a_sr_enter: assert property (sr_wr && dat_i[31] |-> ##[1:2] self_refresh_o) else $error("no entry");
    a_sr_exit: assert property (sr_wr && !dat_i[31] |-> ##[1:2] !self_refresh_o) else $error("no exit");
    a_clk_running: assert property (
        !self_refresh_o && !$past(self_refresh_o) |-> mem_clk_enable_o) else $error("clock stopped");
    a_stop_settled: assert property (
        $fell(mem_clk_enable_o) |-> self_refresh_o && $past(self_refresh_o, 4)) else $error("early stop");
    a_sr_quiet: assert property (
        self_refresh_o && $past(self_refresh_o) |-> !refresh_req_o) else $error("refresh in self-refresh");
    a_init_cause: assert property (
        init_start_o |-> ack_o || $past(ack_o) || $past(ack_o, 2)) else $error("stray init");
    c_stop: cover property ($fell(mem_clk_enable_o));
    c_init: cover property (init_start_o);
    c_refresh: cover property (refresh_req_o);
endmodule
bind dgrc_top dgrc_chk u_chk (.clk_i, .rst_i, .we_i, .ack_o, .geometry_valid_o, .init_start_o, .refresh_req_o,
    .self_refresh_o, .mem_clk_enable_o, .adr_i, .sel_i, .bank_count_o, .column_bits_o, .dat_i);

//--- tb/dgrc_sdram_model.sv
// Purpose: Behavioural stand-in for the attached DDR2 memory.
// Assumes: Commands arrive as controller-side pulses and levels.
// Notes: A stopped clock outside self-refresh would lose the array, so it is flagged.
module dgrc_sdram_model (
    // Commands
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic refresh_req_i,
    input wire logic self_refresh_i,
    input wire logic mem_clk_enable_i,
    // Observations
    output int refresh_cnt_o,
    output logic bad_stop_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic sr_ff;
    always @(posedge clk_i) begin
        sr_ff <= self_refresh_i;
        if (rst_i) begin
            refresh_cnt_o <= 0;
            bad_stop_o <= 1'b0;
        end else begin
            if (refresh_req_i === 1'b1) refresh_cnt_o <= refresh_cnt_o + 1;
            if (!mem_clk_enable_i && !self_refresh_i && !sr_ff) bad_stop_o <= 1'b1;
        end
    end
endmodule

//--- tb/dgrc_top_tb.sv
// Purpose: Self-checking bench for the geometry and refresh control block.
// Assumes: One-cycle bus answer and offsets as handed over.
// Notes: A short refresh interval keeps periods brief.
`include "dgrc_defs.vh"
module dgrc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, er, bad_stop;
    logic [7:0] adr_i = 8'h00;
    logic [3:0] sel_i = 4'hf, bank_count_o, column_bits_o;
    logic [31:0] dat_i = 32'h0000_0000, dat_o, rd;
    logic ack_o, err_o, geometry_valid_o, init_start_o, refresh_req_o, self_refresh_o, mem_clk_enable_o;
    int refresh_cnt, init_cnt = 0, error_cnt = 0, tests_run = 0;
    always #10 clk_i = ~clk_i;
    always @(posedge clk_i) if (init_start_o === 1'b1) init_cnt++;
    dgrc_top DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .err_o,
        .bank_count_o, .column_bits_o, .geometry_valid_o, .init_start_o, .refresh_req_o, .self_refresh_o,
        .mem_clk_enable_o);
    dgrc_sdram_model u_mem (.clk_i, .rst_i, .refresh_req_i(refresh_req_o), .self_refresh_i(self_refresh_o),
        .mem_clk_enable_i(mem_clk_enable_o), .refresh_cnt_o(refresh_cnt), .bad_stop_o(bad_stop));
    task automatic complete_run;
        $display("errors %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'b11, w, a, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 16);
        chk(ack_o | err_o, 32'h1);
        if (ack_o !== 1'b1 && err_o !== 1'b1) complete_run;
        rd = dat_o;
        er = err_o;
        {cyc_i, stb_i} <= 2'b00;
    endtask
    task automatic t_geometry;
        for (int c = 0; c < 8; c++) begin
            wb(`DGRC_OFS_BANK_CFG, 1'b1, {25'h0, c[2:0], 1'b0, c[2:0]});
            repeat (3) @(posedge clk_i);
            chk(bank_count_o, c < 4 ? 32'h1 << c : 32'h0);
            chk(column_bits_o, c < 4 ? 32'h8 + c : 32'h0);
            chk(geometry_valid_o, c < 4 ? 32'h1 : 32'h0);
            wb(`DGRC_OFS_BANK_CFG, 1'b0, 32'h0000_0000);
            chk(rd, {25'h0, c[2:0], 1'b0, c[2:0]});
        end
        chk(init_cnt, 32'h7);
        wb(`DGRC_OFS_BANK_CFG, 1'b1, 32'h0000_0677);
        wb(`DGRC_OFS_BANK_CFG, 1'b1, 32'h0004_0677);
        wb(`DGRC_OFS_BANK_CFG, 1'b1, 32'h0004_0677);
        wb(`DGRC_OFS_BANK_CFG, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0004_0677);
        chk(init_cnt, 32'h9);
    endtask
    task automatic t_refresh;
        int n;
        wb(`DGRC_OFS_REFRESH, 1'b1, 32'h0000_0009);
        for (int k = 0; k < 3; k++) begin
            n = 0;
            do begin
                @(posedge clk_i);
                n++;
            end while (refresh_req_o !== 1'b1 && n < 40);
            chk(n, k == 0 ? 32'h1 : 32'ha);
        end
    endtask
    task automatic t_self_refresh;
        int base;
        wb(`DGRC_OFS_REFRESH, 1'b1, 32'h8000_0009);
        repeat (2) @(posedge clk_i);
        base = refresh_cnt;
        chk(self_refresh_o, 32'h1);
        repeat (12) @(posedge clk_i);
        chk(mem_clk_enable_o, 32'h1);
        wb(`DGRC_OFS_REFRESH, 1'b1, 32'hC000_0009);
        repeat (8) @(posedge clk_i);
        chk(mem_clk_enable_o, 32'h0);
        chk(refresh_cnt, base);
        wb(`DGRC_OFS_STATUS, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        wb(`DGRC_OFS_REFRESH, 1'b1, 32'h0000_0009);
        repeat (3) @(posedge clk_i);
        chk(self_refresh_o, 32'h0);
        chk({mem_clk_enable_o, bad_stop}, 32'h2);
        repeat (9) @(posedge clk_i);
        chk(refresh_cnt, base + 1);
    endtask
    task automatic t_unmapped;
        wb(8'h0C, 1'b1, 32'hFFFF_FFFF);
        chk(er, 32'h1);
        wb(`DGRC_OFS_REFRESH, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_0009);
        wb(`DGRC_OFS_REFRESH, 1'b1, 32'h3FFF_FFFF);
        wb(`DGRC_OFS_REFRESH, 1'b0, 32'h0000_0000);
        chk(rd, 32'h0000_FFFF);
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_geometry;
        t_refresh;
        t_self_refresh;
        t_unmapped;
        complete_run;
    end
endmodule
